//--- dv/gps_checker.sv
// Port assertions for the game port status block
`timescale 1ns/1ps
module gps_checker
	import gps_pkg::*;
#(
	parameter int PULSE_CYC = GPS_PULSE_CYC
) (
	input wire logic core_clk,
	input wire logic resetn,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_rdata,
	input wire logic [3:0] button_in,
	input wire logic [3:0] axis_pin_in,
	input wire logic [3:0] axis_pin_out,
	input wire logic [3:0] axis_pin_oe,
	input wire logic irq
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (!resetn);
	int oe_len_reg;
	// Length of the running low pulse
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) oe_len_reg <= 0;
		else oe_len_reg <= axis_pin_oe[0] ? oe_len_reg + 1 : 0;
	end
	sequence start_s; reg_wr && reg_addr == GPS_OFF_LEGACY; endsequence
	sequence low_s; axis_pin_oe == 4'hf; endsequence
	pulse_start_a: assert property (start_s |=> low_s [*8]) else $error("no pulse");
	pulse_len_a: assert property ($fell(axis_pin_oe[0]) |-> oe_len_reg == PULSE_CYC)
		else $error("pulse length");
	pin_shape_a: assert property (axis_pin_out == 4'h0 && (axis_pin_oe == 4'h0 || axis_pin_oe == 4'hf))
		else $error("pin drive");
	no_pulse_a: assert property (!(reg_wr && reg_addr == GPS_OFF_LEGACY) && axis_pin_oe == 4'h0 |=> axis_pin_oe == 4'h0)
		else $error("stray pulse");
	legacy_read_a: assert property (reg_rd && reg_addr == GPS_OFF_LEGACY |=>
		reg_rdata == {$past(button_in), $past(axis_pin_oe)}) else $error("legacy byte");
	idle_data_a: assert property (!reg_rd |=> reg_rdata == 8'h00) else $error("rdata idle");
	unmapped_a: assert property (reg_rd && reg_addr > GPS_OFF_MASK |=> reg_rdata == 8'h00)
		else $error("unmapped read");
	reset_quiet_a: assert property ($rose(resetn) |-> !irq && axis_pin_oe == 4'h0)
		else $error("reset state");
endmodule : gps_checker

//--- dv/gps_joy_model.sv
// Joystick axis RC model: pins recharge after release
`timescale 1ns/1ps
module gps_joy_model (
	input wire logic core_clk,
	input wire logic [3:0] axis_pin_out,
	input wire logic [3:0] axis_pin_oe,
	output logic [3:0] axis_pin_in
);
	int chg_reg [4];
	// Charge time per axis since release
	always_ff @(posedge core_clk) begin
		for (int i = 0; i < 4; i++) begin
			if (axis_pin_oe[i]) chg_reg[i] <= 0;
			else if (chg_reg[i] < 1000) chg_reg[i] <= chg_reg[i] + 1;
		end
	end
	// Low while driven, high once charged
	always_comb begin
		for (int i = 0; i < 4; i++) begin
			axis_pin_in[i] = axis_pin_oe[i] ? axis_pin_out[i] : chg_reg[i] >= 150 + 100 * i;
		end
	end
endmodule : gps_joy_model

//--- dv/gps_top_bench.sv
// Self-checking bench for the game port status block
`timescale 1ns/1ps
module gps_top_bench;
	import gps_pkg::*;
	localparam int PC = 20;
	logic core_clk = 0;
	logic resetn = 0;
	logic [7:0] reg_addr = 8'h00;
	logic [7:0] reg_wdata = 8'h00;
	logic reg_wr = 0;
	logic reg_rd = 0;
	logic [7:0] reg_rdata;
	logic [3:0] button_in = 4'h0;
	logic [3:0] axis_pin_in, axis_pin_out, axis_pin_oe;
	logic irq;
	logic rd_seen = 0;
	logic [15:0] note;
	logic [15:0] exp_q [$];
	int miscompares = 0;
	int checks = 0;
	int seed = 18056;
	int cyc = 0;
	always #5 core_clk = ~core_clk;
	gps_top #(.PULSE_CYC(PC)) uut (.core_clk(core_clk), .resetn(resetn), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.button_in(button_in), .axis_pin_in(axis_pin_in), .axis_pin_out(axis_pin_out),
		.axis_pin_oe(axis_pin_oe), .irq(irq));
	gps_joy_model joy (.core_clk(core_clk), .axis_pin_out(axis_pin_out),
		.axis_pin_oe(axis_pin_oe), .axis_pin_in(axis_pin_in));
	task automatic chk_bit(input string n, input logic e, input logic s);
		checks++;
		if (s !== e) begin
			miscompares++;
			$display("[ERR] %s expected %b seen %b", n, e, s);
		end
	endtask : chk_bit
	task automatic chk_byte(input logic [7:0] e, input logic [7:0] m, input logic [7:0] s);
		checks++;
		if ((s & m) !== (e & m)) begin
			miscompares++;
			$display("[ERR] reg_rdata expected %h seen %h", e, s);
		end
	endtask : chk_byte
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge core_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1;
		@(posedge core_clk);
		reg_wr <= 0;
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [7:0] e, input logic [7:0] m);
		@(posedge core_clk);
		reg_addr <= a;
		reg_rd <= 1;
		exp_q.push_back({e, m});
		@(posedge core_clk);
		reg_rd <= 0;
	endtask : rd
	task automatic chk_irq(input logic e);
		@(negedge core_clk);
		chk_bit("irq", e, irq);
	endtask : chk_irq
	task end_sim;
		$display("checks %0d miscompares %0d", checks, miscompares);
		if (miscompares == 0 && checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : end_sim
	// Read answers against the oldest note, and the run limit
	always @(posedge core_clk) begin
		cyc++;
		if (cyc > 10000) begin
			miscompares++;
			end_sim();
		end else begin
			if (rd_seen) begin
				note = exp_q.pop_front();
				chk_byte(note[15:8], note[7:0], reg_rdata);
			end
			rd_seen <= reg_rd;
		end
	end
	// Main sequence
	initial begin
		repeat (12) @(posedge core_clk);
		resetn <= 1;
		rd(GPS_OFF_XST, 8'h00, 8'hff);
		rd(8'h3c, 8'h00, 8'hff);
		for (int i = 0; i < 6; i++) begin
			@(posedge core_clk) button_in <= 4'($random(seed));
			@(posedge core_clk);
			rd(GPS_OFF_LEGACY, {button_in, 4'h0}, 8'hff);
		end
		wr(GPS_OFF_LEGACY, 8'h5a);
		rd(GPS_OFF_LEGACY, {button_in, 4'hf}, 8'hff);
		button_in <= 4'h0;
		repeat (600) @(posedge core_clk);
		rd(GPS_OFF_XST, 8'h00, 8'hff);
		$display("legacy test done");
		wr(GPS_OFF_POL, 8'hf0);
		wr(GPS_OFF_MASK, 8'h1f);
		wr(GPS_OFF_CTL, 8'h01);
		wr(GPS_OFF_LEGACY, 8'h00);
		repeat (600) @(posedge core_clk);
		rd(GPS_OFF_XST, 8'h0f, 8'hff);
		chk_irq(1'b1);
		rd(GPS_OFF_CNT_FIRST, 8'h00, 8'hfc);
		rd(GPS_OFF_XST, 8'h0e, 8'hff);
		wr(GPS_OFF_XST, 8'h02);
		rd(GPS_OFF_XST, 8'h0c, 8'hff);
		wr(GPS_OFF_XST, 8'h00);
		rd(GPS_OFF_XST, 8'h0c, 8'hff);
		$display("enhanced test done");
		wr(GPS_OFF_CTL, 8'h03);
		wr(GPS_OFF_LEGACY, 8'h00);
		rd(8'h06, 8'h00, 8'hff);
		repeat (600) @(posedge core_clk);
		rd(GPS_OFF_CNT_FIRST, 8'h00, 8'hfe);
		button_in <= 4'h1;
		repeat (4) @(posedge core_clk);
		rd(GPS_OFF_XST, 8'h10, 8'hf0);
		wr(GPS_OFF_XST, 8'hff);
		rd(GPS_OFF_XST, 8'h00, 8'hff);
		chk_irq(1'b0);
		wr(GPS_OFF_MASK, 8'h00);
		button_in <= 4'h3;
		repeat (4) @(posedge core_clk);
		rd(GPS_OFF_XST, 8'h20, 8'hff);
		chk_irq(1'b0);
		wr(GPS_OFF_MASK, 8'h20);
		chk_irq(1'b1);
		wr(GPS_OFF_XST, 8'h20);
		chk_irq(1'b0);
		wr(GPS_OFF_POL, 8'he0);
		button_in <= 4'h2;
		repeat (4) @(posedge core_clk);
		rd(GPS_OFF_XST, 8'h10, 8'hff);
		$display("event test done");
		repeat (4) @(posedge core_clk);
		end_sim();
	end
endmodule : gps_top_bench
bind gps_top gps_checker #(.PULSE_CYC(PULSE_CYC)) chk (.core_clk(core_clk), .resetn(resetn),
	.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
	.reg_rdata(reg_rdata), .button_in(button_in), .axis_pin_in(axis_pin_in),
	.axis_pin_out(axis_pin_out), .axis_pin_oe(axis_pin_oe), .irq(irq));

//--- hw/gps_btn_edge.sv
// Button edge detection with selectable polarity
`timescale 1ns/1ps
module gps_btn_edge #(
	parameter int N = 4
) (
	input wire logic core_clk,
	input wire logic resetn,
	input wire logic [N-1:0] btn,
	input wire logic [N-1:0] rising,
	output logic [N-1:0] event_pulse
);
	logic [N-1:0] prev_reg;
	logic armed_reg;

	// Previous level, armed after the first sample
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			prev_reg <= '0;
			armed_reg <= 1'b0;
		end else begin
			prev_reg <= btn;
			armed_reg <= 1'b1;
		end
	end

	genvar i;
	generate
		for (i = 0; i < N; i++) begin : g_edge
			// Rising when polarity set, falling otherwise
			assign event_pulse[i] = armed_reg && (rising[i] ?
				(btn[i] && !prev_reg[i]) : (!btn[i] && prev_reg[i])); // R15
		end
	endgenerate
endmodule : gps_btn_edge

//--- hw/gps_cnt_if.sv
// Link between the top and one position counter
`timescale 1ns/1ps
interface gps_cnt_if;
	logic start;
	logic drive;
	logic tick;
	logic pin_high;
	logic [15:0] count;
	logic done;
	modport ctl (output start, output drive, output tick, output pin_high,
		input count, input done);
	modport cnt (input start, input drive, input tick, input pin_high,
		output count, output done);
endinterface : gps_cnt_if

//--- hw/gps_pkg.sv
// Shared constants of the game port status block
package gps_pkg;
	// Register offsets
	localparam logic [7:0] GPS_OFF_CTL = 8'h00;
	localparam logic [7:0] GPS_OFF_LEGACY = 8'h01;
	localparam logic [7:0] GPS_OFF_XST = 8'h02;
	localparam logic [7:0] GPS_OFF_IEN = 8'h03;
	localparam logic [7:0] GPS_OFF_CNT_FIRST = 8'h04;
	localparam logic [7:0] GPS_OFF_CNT_LAST = 8'h0b;
	localparam logic [7:0] GPS_OFF_POL = 8'h0c;
	localparam logic [7:0] GPS_OFF_MASK = 8'h0d;
	// Field positions
	localparam int GPS_CTL_ENH_BIT = 0;
	localparam int GPS_CTL_PRE_A_BIT = 1;
	localparam int GPS_CTL_PRE_B_BIT = 2;
	localparam int GPS_BTN_LSB = 4;
	localparam int GPS_AXIS_LSB = 0;
	// Values after reset, and the control write mask
	localparam logic [7:0] GPS_CTL_RST = 8'h00;
	localparam logic [7:0] GPS_XST_RST = 8'h00;
	localparam logic [7:0] GPS_IEN_RST = 8'h00;
	localparam logic [7:0] GPS_POL_RST = 8'h00;
	localparam logic [7:0] GPS_MASK_RST = 8'h00;
	localparam logic [7:0] GPS_CTL_WMASK = 8'hf7;
	// Timing
	localparam int GPS_CLK_HZ = 100_000_000;
	localparam int GPS_FAST_HZ = 1_000_000;
	localparam int GPS_SLOW_HZ = 500_000;
	localparam int GPS_DIV_FAST = GPS_CLK_HZ / GPS_FAST_HZ;
	localparam int GPS_DIV_SLOW = GPS_CLK_HZ / GPS_SLOW_HZ;
	localparam int GPS_PULSE_US = 10;
	localparam int GPS_PULSE_CYC = (GPS_PULSE_US * (GPS_CLK_HZ / 1_000_000));
	localparam logic [15:0] GPS_CNT_MAX = 16'hffff;
	// Counter states
	typedef enum logic [2:0] {
		GPS_IDLE = 3'b001,
		GPS_HOLD = 3'b010,
		GPS_RUN = 3'b100
	} gps_cnt_state_type;
endpackage : gps_pkg

//--- hw/gps_pos_counter.sv
// One axis position counter
`timescale 1ns/1ps
module gps_pos_counter
	import gps_pkg::*;
(
	input wire logic core_clk,
	input wire logic resetn,
	gps_cnt_if.cnt link
);
	gps_cnt_state_type state_reg;
	logic [15:0] count_reg;
	logic done_reg;

	assign link.count = count_reg;
	assign link.done = done_reg;

	// Sequence: hold while driven low, then count until pin high
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			state_reg <= GPS_IDLE;
			count_reg <= 16'h0000;
			done_reg <= 1'b0;
		end else begin
			done_reg <= 1'b0;
			if (link.start) begin
				state_reg <= GPS_HOLD;
				count_reg <= 16'h0000; // R3
			end else begin
				case (state_reg)
					GPS_IDLE: begin
						state_reg <= GPS_IDLE;
					end
					GPS_HOLD: begin
						if (!link.drive) begin
							state_reg <= GPS_RUN;
						end
					end
					GPS_RUN: begin
						if (link.pin_high || count_reg == GPS_CNT_MAX) begin
							state_reg <= GPS_IDLE; // R16 R14
							done_reg <= 1'b1;
						end else if (link.tick) begin
							count_reg <= count_reg + 16'h0001; // R16
						end
					end
					default: begin
						state_reg <= GPS_IDLE;
					end
				endcase
			end
		end
	end
endmodule : gps_pos_counter

//--- hw/gps_top.sv
// Game port status, extended status and position measurement
// Functional notes
// [R1] Legacy status readable in every mode
// [R2] Legacy status write pulses all axis pins low
// [R3] Enhanced mode write also zeroes counters
// [R4] Bits 7..4 show raw button levels
// [R5] Bits 3..0 show axis pins driven low
// [R6] Button event flags latch in bits 7..4
// [R7] Writing one clears extended flag
// [R8] Counter read clears its ready flag
// [R9] Extended flags set only in enhanced mode
// [R10] Bits 3..0 flag counter ready
// [R11] Extended flags zero after reset
// [R12] Control bit 0 selects enhanced mode
// [R13] Counters tick 1 MHz or 500 kHz prescaled
// [R14] Counter saturates at full scale
// [R15] Button events edge triggered, polarity selected
// [R16] Counter runs until pin high, then ready
`timescale 1ns/1ps
module gps_top
	import gps_pkg::*;
#(
	parameter int PULSE_CYC = GPS_PULSE_CYC
) (
	input wire logic core_clk,
	input wire logic resetn,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	input wire logic [3:0] button_in,
	input wire logic [3:0] axis_pin_in,
	output logic [3:0] axis_pin_out,
	output logic [3:0] axis_pin_oe,
	output logic irq
);
	logic [7:0] game_port_control_reg;
	logic [7:0] extended_event_status_reg;
	logic [7:0] extended_event_status_next;
	logic [7:0] game_irq_enable_reg;
	logic [7:0] button_event_polarity_reg;
	logic [7:0] irq_mask_reg;
	logic [7:0] rdata_reg;
	logic [7:0] legacy_pin_status;
	logic enh;
	logic wr_legacy;
	logic wr_xst;
	logic rd_cnt;
	logic [1:0] rd_cnt_idx;
	logic [3:0] rdy_clr;
	logic [3:0] rdy_set;
	logic [3:0] btn_evt;
	logic [7:0] xst_set;
	logic [7:0] xst_clr;
	logic drive_reg;
	logic [15:0] pulse_cnt_reg;
	logic [7:0] fast_div_reg;
	logic fast_tick_reg;
	logic slow_phase_reg;
	logic tick_a;
	logic tick_b;
	logic [15:0] cnt_val [4];
	logic [3:0] cnt_done;

	// Mode select
	assign enh = game_port_control_reg[GPS_CTL_ENH_BIT]; // R12

	// Access decode
	assign wr_legacy = reg_wr && (reg_addr == GPS_OFF_LEGACY);
	assign wr_xst = reg_wr && (reg_addr == GPS_OFF_XST);
	assign rd_cnt = reg_rd && (reg_addr >= GPS_OFF_CNT_FIRST)
		&& (reg_addr <= GPS_OFF_CNT_LAST);
	assign rd_cnt_idx = reg_addr[2:1] - 2'b10;

	// Control register
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			game_port_control_reg <= GPS_CTL_RST;
		end else if (reg_wr && reg_addr == GPS_OFF_CTL) begin
			game_port_control_reg <= reg_wdata & GPS_CTL_WMASK; // R12
		end
	end

	// Interrupt enable register
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			game_irq_enable_reg <= GPS_IEN_RST;
		end else if (reg_wr && reg_addr == GPS_OFF_IEN) begin
			game_irq_enable_reg <= reg_wdata;
		end
	end

	// Event polarity register
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			button_event_polarity_reg <= GPS_POL_RST;
		end else if (reg_wr && reg_addr == GPS_OFF_POL) begin
			button_event_polarity_reg <= reg_wdata;
		end
	end

	// Interrupt mask register
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			irq_mask_reg <= GPS_MASK_RST;
		end else if (reg_wr && reg_addr == GPS_OFF_MASK) begin
			irq_mask_reg <= reg_wdata;
		end
	end

	// Axis low pulse timer, restarted by any legacy write
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			drive_reg <= 1'b0;
			pulse_cnt_reg <= 16'h0000;
		end else if (wr_legacy) begin
			drive_reg <= 1'b1; // R2
			pulse_cnt_reg <= 16'(PULSE_CYC - 1);
		end else if (drive_reg) begin
			if (pulse_cnt_reg == 16'h0000) begin
				drive_reg <= 1'b0;
			end else begin
				pulse_cnt_reg <= pulse_cnt_reg - 16'h0001;
			end
		end
	end

	// Axis pins pulled low during the pulse only
	assign axis_pin_out = 4'h0;
	assign axis_pin_oe = {4{drive_reg}}; // R2

	// 1 MHz tick divider
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			fast_div_reg <= 8'h00;
			fast_tick_reg <= 1'b0;
		end else if (fast_div_reg == 8'(GPS_DIV_FAST - 1)) begin
			fast_div_reg <= 8'h00;
			fast_tick_reg <= 1'b1; // R13
		end else begin
			fast_div_reg <= fast_div_reg + 8'h01;
			fast_tick_reg <= 1'b0;
		end
	end

	// Every second fast tick gives 500 kHz
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			slow_phase_reg <= 1'b0;
		end else if (fast_tick_reg) begin
			slow_phase_reg <= !slow_phase_reg;
		end
	end

	// Per device tick choice
	assign tick_a = fast_tick_reg && (!game_port_control_reg[GPS_CTL_PRE_A_BIT]
		|| slow_phase_reg); // R13
	assign tick_b = fast_tick_reg && (!game_port_control_reg[GPS_CTL_PRE_B_BIT]
		|| slow_phase_reg); // R13

	// Position counters, index 0 AX, 1 AY, 2 BX, 3 BY
	genvar k;
	generate
		for (k = 0; k < 4; k++) begin : g_cnt
			gps_cnt_if link ();
			assign link.start = wr_legacy && enh; // R3
			assign link.drive = drive_reg;
			assign link.tick = (k < 2) ? tick_a : tick_b;
			assign link.pin_high = axis_pin_in[k];
			assign cnt_val[k] = link.count;
			assign cnt_done[k] = link.done;
			gps_pos_counter u_cnt (
				.core_clk(core_clk),
				.resetn(resetn),
				.link(link)
			);
			// Read of either byte clears this ready flag
			assign rdy_clr[k] = rd_cnt && (rd_cnt_idx == 2'(k)); // R8
			assign rdy_set[k] = cnt_done[k] && enh; // R10 R16
		end
	endgenerate

	// Button edge events
	gps_btn_edge #(
		.N(4)
	) u_btn (
		.core_clk(core_clk),
		.resetn(resetn),
		.btn(button_in),
		.rising(button_event_polarity_reg[7:4]),
		.event_pulse(btn_evt)
	);

	// Extended status set and clear terms
	assign xst_set = enh ? {btn_evt, rdy_set} : 8'h00; // R6 R9
	assign xst_clr = (wr_xst ? reg_wdata : 8'h00) | {4'h0, rdy_clr}; // R7 R8

	// Set wins over a clear in the same cycle
	always_comb begin
		extended_event_status_next = (extended_event_status_reg & ~xst_clr)
			| xst_set; // R7
	end

	// Extended status register
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			extended_event_status_reg <= GPS_XST_RST; // R11
		end else begin
			extended_event_status_reg <= extended_event_status_next;
		end
	end

	// Live pin view
	assign legacy_pin_status = {button_in, axis_pin_oe}; // R4 R5

	// Read data, one cycle after the strobe
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			rdata_reg <= 8'h00;
		end else if (reg_rd) begin
			case (reg_addr)
				GPS_OFF_CTL: rdata_reg <= game_port_control_reg;
				GPS_OFF_LEGACY: rdata_reg <= legacy_pin_status; // R1
				GPS_OFF_XST: rdata_reg <= extended_event_status_reg;
				GPS_OFF_IEN: rdata_reg <= game_irq_enable_reg;
				GPS_OFF_POL: rdata_reg <= button_event_polarity_reg;
				GPS_OFF_MASK: rdata_reg <= irq_mask_reg;
				default: begin
					if (rd_cnt) begin
						rdata_reg <= reg_addr[0] ? cnt_val[rd_cnt_idx][15:8]
							: cnt_val[rd_cnt_idx][7:0];
					end else begin
						rdata_reg <= 8'h00;
					end
				end
			endcase
		end else begin
			rdata_reg <= 8'h00;
		end
	end
	assign reg_rdata = rdata_reg;

	// Level interrupt from unmasked flags
	assign irq = |(extended_event_status_reg & irq_mask_reg);
endmodule : gps_top
